//--- common/ofp_pkg.sv
// Package with constants and types for the output fallback protection block
// ----------------------------------------------------------------------------
// Function
// RULE_01: On stop or any exception every output takes its configured default; pulse-train outputs take 0 instead.
// RULE_02: Pulse-train outputs fall back to 0 and that value is fixed.
// RULE_03: Sourcing outputs are protected in clusters of up to four.
// RULE_04: A fault with protection enabled forces its whole cluster to 0.
// RULE_05: A shut cluster is rearmed about once per second to retest.
// RULE_06: Only a high output shorted to 0 V counts as a fault.
// RULE_07: The protection enable bit resets to 0 and can disable rearming.
// RULE_08: Sinking outputs have no protection and report nothing.
// RULE_09: Relay outputs have no protection and report nothing.
// RULE_10: Outputs without a special function follow the application value.
// RULE_11: Output 1 carries channel 0 direction in CW/CCW mode, not channel 1.
// RULE_12: Outputs 2,3 are reflex for counter 0/2 and 4,5 for counter 1/3.
// RULE_13: With protection disabled, cluster outputs follow their commands.
// ----------------------------------------------------------------------------
package ofp_pkg;
  // Register word offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DFLT = 4'h1;
  localparam logic [3:0] ADDR_FN0 = 4'h2;
  localparam logic [3:0] ADDR_FN1 = 4'h3;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h5;
  localparam logic [3:0] ADDR_SHUT = 4'h6;
  localparam logic [3:0] ADDR_OUT = 4'h7;
  // Control bit positions
  localparam int CTRL_PROT = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_CWCCW = 2;
  localparam int CTRL_SRC = 3;
  // Status bit positions
  localparam int ST_FAULT = 0;
  localparam int ST_REARM = 1;
  localparam int ST_FALLBACK = 2;
  localparam int ST_W = 3;
  // Cluster size
  localparam int CL_SIZE = 4;
  // Rearm period
  localparam int REARM_MS = 1000;
  localparam int CLK_HZ = 10000000;
  localparam int REARM_CYC = (CLK_HZ / 1000) * REARM_MS;
  // Output function codes, two bits per output
  typedef enum logic [1:0]
  {
    OFP_FN_PLAIN = 2'h0,
    OFP_FN_PULSE = 2'h1,
    OFP_FN_TRAIN = 2'h2,
    OFP_FN_REFLEX = 2'h3
  } ofp_fn_e;
  // Special function sources carried together
  typedef struct packed
  {
    logic pulse0;
    logic pulse1;
    logic train0;
    logic train1;
    logic train0_dir;
    logic [1:0] reflex_a;
    logic [1:0] reflex_b;
  } ofp_src_s;
endpackage

//--- rtl/ofp_top.sv
// Output fallback and short-circuit protection with Avalon-MM registers
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
module ofp_top #(
  parameter int N_OUT = 16,
  parameter int REARM_CYCLES = ofp_pkg::REARM_CYC
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Controller state and application values
  input wire logic exception_i,
  input wire logic [N_OUT-1:0] app_value_i,
  input wire ofp_pkg::ofp_src_s src_i,
  // Load side
  input wire logic [N_OUT-1:0] short_sense_i,
  output logic [N_OUT-1:0] out_o,
  output logic irq_o
);
  localparam int N_CL = (N_OUT + ofp_pkg::CL_SIZE - 1) / ofp_pkg::CL_SIZE;

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [3:0] ctrl;
  logic [3:0] next_ctrl;
  logic [N_OUT-1:0] dflt;
  logic [N_OUT-1:0] next_dflt;
  logic [31:0] fn_lo;
  logic [31:0] next_fn_lo;
  logic [31:0] fn_hi;
  logic [31:0] next_fn_hi;
  logic [ofp_pkg::ST_W-1:0] stat;
  logic [ofp_pkg::ST_W-1:0] next_stat;
  logic [ofp_pkg::ST_W-1:0] mask;
  logic [ofp_pkg::ST_W-1:0] next_mask;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic rd_done;
  logic next_rd_done;
  logic [N_OUT-1:0] out_q;
  logic [N_OUT-1:0] next_out;
  logic [N_CL-1:0] shut;
  logic [N_CL-1:0] next_shut;
  logic [31:0] rearm_cnt;
  logic [31:0] next_rearm_cnt;
  logic rearm_tick;
  logic [N_OUT-1:0] cmd;
  logic [N_OUT-1:0] fault;
  logic [N_CL-1:0] cl_fault;
  logic fallback;
  logic wr_en;

  // Function code of output i
  function automatic ofp_pkg::ofp_fn_e fn_of(input int i);
    logic [63:0] all;
    all = {fn_hi, fn_lo};
    return ofp_pkg::ofp_fn_e'(all[2*i +: 2]);
  endfunction

  // Reads take one wait cycle so read data leave a flip-flop
  assign avs_waitrequest_o = avs_read_i & ~rd_done;
  assign wr_en = avs_write_i;
  assign avs_readdata_o = rdata;
  assign fallback = ctrl[ofp_pkg::CTRL_STOP] | exception_i;
  assign rearm_tick = (rearm_cnt == 32'(REARM_CYCLES - 1));

  // ----------------------------------------------------------------------------
  // Output function routing
  // ----------------------------------------------------------------------------
  always_comb
  begin
    cmd = app_value_i;
    for (int i = 0; i < N_OUT; i++)
    begin
      case (fn_of(i))
        ofp_pkg::OFP_FN_PLAIN: cmd[i] = app_value_i[i]; // RULE_10
        ofp_pkg::OFP_FN_PULSE: cmd[i] = (i == 0) ? src_i.pulse0 :
                                        (i == 1) ? src_i.pulse1 :
                                        app_value_i[i];
        ofp_pkg::OFP_FN_TRAIN:
        begin
          if (i == 0)
            cmd[i] = src_i.train0;
          else if (i == 1)
            cmd[i] = ctrl[ofp_pkg::CTRL_CWCCW] ? src_i.train0_dir
                                               : src_i.train1; // RULE_11
          else
            cmd[i] = src_i.train0_dir;
        end
        ofp_pkg::OFP_FN_REFLEX: cmd[i] = (i == 2) ? src_i.reflex_a[0] :
                                         (i == 3) ? src_i.reflex_a[1] :
                                         (i == 4) ? src_i.reflex_b[0] :
                                         (i == 5) ? src_i.reflex_b[1] :
                                         app_value_i[i]; // RULE_12
        default: cmd[i] = app_value_i[i];
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Fault detection per cluster
  // ----------------------------------------------------------------------------
  // Sensing only counts while the pin is driven high, so a low pin tied to
  // the supply never trips; sinking and relay builds ignore sensing entirely.
  assign fault = out_q & short_sense_i & {N_OUT{ctrl[ofp_pkg::CTRL_SRC]}};
  // RULE_06 RULE_08 RULE_09

  genvar g;
  generate
    for (g = 0; g < N_CL; g++)
    begin : g_cl
      localparam int LO = g * ofp_pkg::CL_SIZE;
      localparam int HI = (LO + ofp_pkg::CL_SIZE > N_OUT) ? N_OUT - 1
                          : LO + ofp_pkg::CL_SIZE - 1;
      assign cl_fault[g] = |fault[HI:LO]; // RULE_03
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    next_ctrl = ctrl;
    next_dflt = dflt;
    next_fn_lo = fn_lo;
    next_fn_hi = fn_hi;
    next_mask = mask;
    next_stat = stat;
    next_rdata = rdata;
    next_rd_done = avs_read_i & ~rd_done;
    next_shut = shut;
    next_rearm_cnt = rearm_tick ? 32'h0 : rearm_cnt + 32'h1;
    if (wr_en)
    begin
      case (avs_address_i)
        ofp_pkg::ADDR_CTRL: next_ctrl = avs_writedata_i[3:0];
        ofp_pkg::ADDR_DFLT: next_dflt = avs_writedata_i[N_OUT-1:0];
        ofp_pkg::ADDR_FN0: next_fn_lo = avs_writedata_i;
        ofp_pkg::ADDR_FN1: next_fn_hi = avs_writedata_i;
        ofp_pkg::ADDR_STAT:
          next_stat = stat & ~avs_writedata_i[ofp_pkg::ST_W-1:0];
        ofp_pkg::ADDR_MASK: next_mask = avs_writedata_i[ofp_pkg::ST_W-1:0];
        default: next_mask = mask;
      endcase
    end
    if (avs_read_i & ~rd_done)
    begin
      case (avs_address_i)
        ofp_pkg::ADDR_CTRL: next_rdata = 32'(ctrl);
        ofp_pkg::ADDR_DFLT: next_rdata = 32'(dflt);
        ofp_pkg::ADDR_FN0: next_rdata = fn_lo;
        ofp_pkg::ADDR_FN1: next_rdata = fn_hi;
        ofp_pkg::ADDR_STAT: next_rdata = 32'(stat);
        ofp_pkg::ADDR_MASK: next_rdata = 32'(mask);
        ofp_pkg::ADDR_SHUT: next_rdata = 32'(shut);
        ofp_pkg::ADDR_OUT: next_rdata = 32'(out_q);
        default: next_rdata = 32'h0;
      endcase
    end
    // Shutdown only with protection on; clearing the bit releases clusters
    if (ctrl[ofp_pkg::CTRL_PROT])
    begin
      if (rearm_tick)
        next_shut = '0; // RULE_05
      else
        next_shut = shut | cl_fault; // RULE_04
    end
    else
      next_shut = '0; // RULE_13
    // Hardware sets win over a clear in the same cycle
    if (ctrl[ofp_pkg::CTRL_PROT] & |cl_fault & ~rearm_tick)
      next_stat[ofp_pkg::ST_FAULT] = 1'b1;
    if (ctrl[ofp_pkg::CTRL_PROT] & rearm_tick & |shut)
      next_stat[ofp_pkg::ST_REARM] = 1'b1;
    if (fallback)
      next_stat[ofp_pkg::ST_FALLBACK] = 1'b1;
    for (int i = 0; i < N_OUT; i++)
    begin
      if (fallback)
        next_out[i] = (fn_of(i) == ofp_pkg::OFP_FN_TRAIN) ? 1'b0 // RULE_02
                      : dflt[i]; // RULE_01
      else if (next_shut[i / ofp_pkg::CL_SIZE])
        next_out[i] = 1'b0; // RULE_04
      else
        next_out[i] = cmd[i];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl <= 4'h8; // RULE_07
      dflt <= '0;
      fn_lo <= 32'h0;
      fn_hi <= 32'h0;
      stat <= '0;
      mask <= '0;
      rdata <= 32'h0;
      rd_done <= 1'b0;
      shut <= '0;
      rearm_cnt <= 32'h0;
      out_q <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      dflt <= next_dflt;
      fn_lo <= next_fn_lo;
      fn_hi <= next_fn_hi;
      stat <= next_stat;
      mask <= next_mask;
      rdata <= next_rdata;
      rd_done <= next_rd_done;
      shut <= next_shut;
      rearm_cnt <= next_rearm_cnt;
      out_q <= next_out;
    end
  end

  assign out_o = out_q;
  assign irq_o = |(stat & mask);

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  a_fallback_dflt: assert property ( // RULE_01
    fallback && fn_of(5) != ofp_pkg::OFP_FN_TRAIN |=> out_q[5] == $past(dflt[5]))
    else $error("fallback output not at default");
  a_train_zero: assert property ( // RULE_02
    fallback && fn_of(0) == ofp_pkg::OFP_FN_TRAIN |=> !out_q[0])
    else $error("train output not zero in fallback");
  a_cluster_off: assert property ( // RULE_04
    !fallback && ctrl[ofp_pkg::CTRL_PROT] && cl_fault[0] && !rearm_tick
    |=> out_q[3:0] == 4'h0)
    else $error("faulted cluster not forced low");
  a_cluster_scope: assert property ( // RULE_03
    ctrl[ofp_pkg::CTRL_PROT] && cl_fault[0] && !shut[1] && !cl_fault[1]
    && !rearm_tick |=> !shut[1])
    else $error("fault spilled to next cluster");
  a_rearm_clear: assert property ( // RULE_05
    rearm_tick && ctrl[ofp_pkg::CTRL_PROT] |=> shut == '0)
    else $error("rearm did not release clusters");
  a_low_noflag: assert property ( // RULE_06
    out_q == '0 |=> !$rose(stat[ofp_pkg::ST_FAULT]))
    else $error("fault flagged on low outputs");
  a_prot_off: assert property ( // RULE_13
    !ctrl[ofp_pkg::CTRL_PROT] |=> shut == '0)
    else $error("shutdown while protection off");
  a_plain_follow: assert property ( // RULE_10
    !fallback && fn_of(7) == ofp_pkg::OFP_FN_PLAIN && !next_shut[1]
    |=> out_q[7] == $past(app_value_i[7]))
    else $error("plain output not following value");
  a_dir_route: assert property ( // RULE_11
    !fallback && ctrl[ofp_pkg::CTRL_CWCCW] && fn_of(1) == ofp_pkg::OFP_FN_TRAIN
    && !next_shut[0] |=> out_q[1] == $past(src_i.train0_dir))
    else $error("direction not routed to output 1");

  // Routing and flag checks; each waits one edge for the output or status flop
  a_train_one: assert property ( // RULE_11
    !fallback && !ctrl[ofp_pkg::CTRL_CWCCW]
    && fn_of(1) == ofp_pkg::OFP_FN_TRAIN
    && !next_shut[0] |=> out_q[1] == $past(src_i.train1))
    else $error("second train channel not on output 1");
  a_reflex_route: assert property ( // RULE_12
    !fallback && fn_of(2) == ofp_pkg::OFP_FN_REFLEX && !next_shut[0]
    |=> out_q[2] == $past(src_i.reflex_a[0]))
    else $error("reflex output not routed");
  a_fault_flag: assert property ( // RULE_04
    ctrl[ofp_pkg::CTRL_PROT] && cl_fault != '0 && !rearm_tick
    |=> stat[ofp_pkg::ST_FAULT])
    else $error("fault flag not set");

  // Sink and relay builds have no sensing, so nothing may shut or flag
  a_sink_quiet: assert property ( // RULE_08 RULE_09
    !ctrl[ofp_pkg::CTRL_SRC] && shut == '0 |=> shut == '0)
    else $error("shutdown on unprotected outputs");
  a_sink_noflag: assert property ( // RULE_08 RULE_09
    !ctrl[ofp_pkg::CTRL_SRC] && !stat[ofp_pkg::ST_FAULT]
    |=> !stat[ofp_pkg::ST_FAULT])
    else $error("fault flagged on unprotected outputs");

  c_fault_shut: cover property (ctrl[ofp_pkg::CTRL_PROT] && cl_fault != '0);
  c_rearm: cover property (rearm_tick && shut != '0);
  c_fallback: cover property ($rose(fallback));
  c_irq: cover property ($rose(irq_o));
  c_pulse: cover property (fn_of(0) == ofp_pkg::OFP_FN_PULSE && src_i.pulse0);
endmodule

//--- verification/ofp_load_model.sv
// Model of the load wiring that feeds the overcurrent sense lines
`timescale 1ns/10ps
module ofp_load_model #(
  parameter int N = 14
)
(
  // Output pins and wiring faults
  input wire logic [N-1:0] out_i,
  input wire logic [N-1:0] short_gnd_i,
  input wire logic [N-1:0] short_sup_i,
  // Sense lines
  output logic [N-1:0] sense_o
);
  // ----------------------------------------------------------------
  // Current sense
  // ----------------------------------------------------------------
  // Current flows whenever a pin fights its short, in either polarity,
  // so the block itself must tell the two cases apart
  assign sense_o = (out_i & short_gnd_i) | (~out_i & short_sup_i);
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the output fallback and protection block
`timescale 1ns/10ps
module tb_top;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic exception_i = 1'b0;
  logic [13:0] app_value_i = 14'h0;
  ofp_pkg::ofp_src_s src_i = '0;
  logic [13:0] short_sense_i;
  logic [13:0] out_o;
  logic irq_o;
  logic [13:0] gnd = 14'h0;
  logic [13:0] sup = 14'h0;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Fourteen outputs leave a last cluster of two
  ofp_top #(.N_OUT(14), .REARM_CYCLES(50)) u_dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .exception_i(exception_i),
    .app_value_i(app_value_i), .src_i(src_i),
    .short_sense_i(short_sense_i), .out_o(out_o), .irq_o(irq_o));
  ofp_load_model #(.N(14)) u_load (.out_i(out_o), .short_gnd_i(gnd),
    .short_sup_i(sup), .sense_o(short_sense_i));
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic ochk(input logic [13:0] e);
    chk({18'h0, out_o}, {18'h0, e});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_fallback();
    wr(ofp_pkg::ADDR_FN0, 32'h2);
    wr(ofp_pkg::ADDR_DFLT, 32'h3fff);
    wr(ofp_pkg::ADDR_MASK, 32'h4);
    wr(ofp_pkg::ADDR_CTRL, 32'ha);
    step(3);
    ochk(14'h3ffe);
    chk({31'h0, irq_o}, 32'h1);
    wr(ofp_pkg::ADDR_MASK, 32'h0);
    step(3);
    chk({31'h0, irq_o}, 32'h0);
    wr(ofp_pkg::ADDR_CTRL, 32'h8);
    exception_i <= 1'b1;
    step(3);
    ochk(14'h3ffe);
    exception_i <= 1'b0;
    step(3);
    ochk(14'h0);
    wr(ofp_pkg::ADDR_STAT, 32'h7);
    rdchk(ofp_pkg::ADDR_STAT, 32'h4, 32'h0);
  endtask
  task automatic t_special();
    wr(ofp_pkg::ADDR_FN0, 32'h8);
    src_i.train0_dir <= 1'b1;
    wr(ofp_pkg::ADDR_CTRL, 32'hc);
    step(3);
    ochk(14'h2);
    wr(ofp_pkg::ADDR_CTRL, 32'h8);
    step(3);
    ochk(14'h0);
    wr(ofp_pkg::ADDR_FN0, 32'h5);
    src_i <= 9'h100;
    step(3);
    ochk(14'h1);
    wr(ofp_pkg::ADDR_FN0, 32'hff0);
    src_i <= 9'h006;
    step(3);
    ochk(14'h24);
    src_i <= '0;
    wr(ofp_pkg::ADDR_FN0, 32'h0);
  endtask
  task automatic t_short();
    int hi;
    int bad;
    hi = 0;
    bad = 0;
    app_value_i <= 14'h3fff;
    wr(ofp_pkg::ADDR_CTRL, 32'h9);
    gnd <= 14'h2000;
    step(2);
    // Rearm retries may let the cluster pulse high for a cycle or two
    repeat (100)
    begin
      @(posedge clk_sys_i);
      if (out_o[13:12] !== 2'b00) hi++;
      if (out_o[11:0] !== 12'hfff) bad++;
    end
    chk(32'(hi > 6), 32'h0);
    chk(32'(bad), 32'h0);
    rdchk(ofp_pkg::ADDR_STAT, 32'h1, 32'h1);
    gnd <= 14'h0;
    for (int i = 0; i < 60 && out_o[13:12] !== 2'b11; i++) step(1);
    ochk(14'h3fff);
  endtask
  task automatic t_ignored(input logic [31:0] c, input logic [13:0] a,
                           input logic [13:0] g, input logic [13:0] s);
    wr(ofp_pkg::ADDR_CTRL, c);
    app_value_i <= a;
    gnd <= g;
    sup <= s;
    wr(ofp_pkg::ADDR_STAT, 32'h7);
    step(4);
    ochk(a);
    rdchk(ofp_pkg::ADDR_STAT, 32'h1, 32'h0);
    gnd <= 14'h0;
    sup <= 14'h0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    step(20);
    nrst_i <= 1'b1;
    rdchk(ofp_pkg::ADDR_CTRL, 32'hffffffff, 32'h8);
    rdchk(4'hf, 32'hffffffff, 32'h0);
    app_value_i <= 14'h2a5c;
    step(3);
    ochk(14'h2a5c);
    app_value_i <= 14'h0;
    t_fallback();
    t_special();
    t_short();
    t_ignored(32'h8, 14'h3fff, 14'h2000, 14'h0);
    t_ignored(32'h1, 14'h3fff, 14'h2000, 14'h0);
    t_ignored(32'h9, 14'h1fff, 14'h0, 14'h2000);
    results();
  end
endmodule
